// *** logic/rci_edge_sync.sv ***
// Purpose: synchronise the received input and produce edge strobes
// Assumes: input is asynchronous to clk_sys
// Notes:   three stages; a change counts once the second and third agree
module rci_edge_sync (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic clkEn,
    // pin side
    input  wire logic rxPin,
    // level and strobes
    output logic      rxLevel,
    output logic      riseStb,
    output logic      fallStb
);

    logic [2:0] syncFf;
    logic       lvlFf;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            syncFf <= 3'h0;
        end else if (clkEn) begin
            syncFf <= {syncFf[1:0], rxPin};
        end
    end

    // only stages two and three are compared; stage one may be metastable
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lvlFf   <= 1'b0;
            riseStb <= 1'b0;
            fallStb <= 1'b0;
        end else if (clkEn) begin
            riseStb <= 1'b0;
            fallStb <= 1'b0;
            if (syncFf[1] == syncFf[2] && syncFf[2] != lvlFf) begin
                lvlFf   <= syncFf[2];
                riseStb <= syncFf[2];
                fallStb <= !syncFf[2];
            end
        end
        // strobes hold while frozen so an edge seen just before a stall is not lost
    end

    assign rxLevel = lvlFf;

endmodule

// *** logic/rci_irq_flags.sv ***
// Purpose: interrupt cause flags, enables and length down counter of the remote-control unit
// Assumes: byte registers over a plain strobe port, read data one cycle after the read strobe
// Notes:   flags are write-one-to-clear, a set in the same cycle wins over the clear

// Operation
// - underflow enable at mask bit 0, read/write, reset zero
// - flag register at 0x5347: fall bit 2, rise bit 1, underflow bit 0
// - falling edge sets fall flag only while its enable is one
// - rising edge sets rise flag only while its enable is one
// - counter underflow sets underflow flag only while its enable is one
// - interrupt request is high whenever any flag is set
// - writing one clears a flag, writing zero leaves it
// - flags read one after their cause, zero after reset
// - length counter counts down from written value, stops at zero, signals underflow
// - mask register at 0x5346: fall enable bit 2, rise enable bit 1
module rci_irq_flags (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       clkEn,
    // register port
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0]  regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic [7:0]       regRdData,
    // counter tick from the shared prescaler
    input  wire logic        cntTick,
    // received input pin
    input  wire logic        rxPin,
    // interrupt request toward the chip interrupt controller
    output logic             irqReq
);

    // ------------------------------------------------------------
    // bus request bundle
    // ------------------------------------------------------------
    rci_pkg::rci_bus_s   bus;
    rci_pkg::rci_cause_s cause;

    assign bus.wrEn   = regWrEn;
    assign bus.rdEn   = regRdEn;
    assign bus.addr   = regAddr;
    assign bus.wrData = regWrData;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ref_a);
        hit = (a == ref_a);
    endfunction

    // ------------------------------------------------------------
    // input edge detection
    // ------------------------------------------------------------
    logic rxLevel;
    logic riseStb;
    logic fallStb;

    rci_edge_sync u_edge (
        .clk_sys (clk_sys),
        .srst    (srst),
        .clkEn   (clkEn),
        .rxPin   (rxPin),
        .rxLevel (rxLevel),
        .riseStb (riseStb),
        .fallStb (fallStb)
    );

    // ------------------------------------------------------------
    // mask register
    // ------------------------------------------------------------
    logic [2:0] mask_ff;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mask_ff <= rci_pkg::RST_MASK;
        end else if (clkEn && bus.wrEn && hit(bus.addr, rci_pkg::ADDR_MASK)) begin
            mask_ff <= bus.wrData[2:0];
        end
    end

    // ------------------------------------------------------------
    // length down counter
    // ------------------------------------------------------------
    logic [7:0]        lcnt_ff;
    rci_pkg::rci_cnt_e cntState_ff;
    logic              underflowStb;

    // a write restarts the count; writing zero stops it without an underflow
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lcnt_ff     <= rci_pkg::RST_LCNT;
            cntState_ff <= rci_pkg::CNT_IDLE;
        end else if (clkEn) begin
            if (bus.wrEn && hit(bus.addr, rci_pkg::ADDR_LCNT)) begin
                lcnt_ff     <= bus.wrData;
                cntState_ff <= (bus.wrData != rci_pkg::DATA_ZERO) ? rci_pkg::CNT_RUN : rci_pkg::CNT_IDLE;
            end else begin
                case (cntState_ff)
                    rci_pkg::CNT_IDLE: begin
                        cntState_ff <= rci_pkg::CNT_IDLE;
                    end
                    rci_pkg::CNT_RUN: begin
                        if (cntTick) begin
                            lcnt_ff <= lcnt_ff - 8'h01;
                            if (lcnt_ff == 8'h01) begin
                                cntState_ff <= rci_pkg::CNT_IDLE;
                            end
                        end
                    end
                    default: begin
                        cntState_ff <= rci_pkg::CNT_IDLE;
                    end
                endcase
            end
        end
    end

    // underflow is the step from one to zero while running
    assign underflowStb = clkEn && (cntState_ff == rci_pkg::CNT_RUN) && cntTick
                          && (lcnt_ff == 8'h01)
                          && !(bus.wrEn && hit(bus.addr, rci_pkg::ADDR_LCNT));

    // ------------------------------------------------------------
    // cause flags
    // ------------------------------------------------------------
    logic [2:0] flags_ff;
    logic [2:0] nxt_flags;
    logic [2:0] setVec;
    logic [2:0] clrVec;

    assign cause.fall      = fallStb && mask_ff[rci_pkg::BIT_FALL];
    assign cause.rise      = riseStb && mask_ff[rci_pkg::BIT_RISE];
    assign cause.underflow = underflowStb && mask_ff[rci_pkg::BIT_UNDERFLOW];

    always_comb begin
        setVec = {cause.fall, cause.rise, cause.underflow};
        clrVec = (clkEn && bus.wrEn && hit(bus.addr, rci_pkg::ADDR_FLAGS)) ? bus.wrData[2:0] : 3'h0;
        // set wins over a clear in the same cycle so no event is lost
        nxt_flags = (flags_ff & ~clrVec) | setVec;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flags_ff <= rci_pkg::RST_FLAGS;
        end else if (clkEn) begin
            flags_ff <= nxt_flags;
        end
    end

    // registered request: loaded from the next flags, so high in the same cycle as the flag register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqReq <= 1'b0;
        end else if (clkEn) begin
            irqReq <= |nxt_flags;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdData <= rci_pkg::DATA_ZERO;
        end else if (clkEn) begin
            regRdData <= rci_pkg::DATA_ZERO;
            if (bus.rdEn) begin
                case (bus.addr)
                    rci_pkg::ADDR_MASK:  regRdData <= {5'h00, mask_ff};
                    rci_pkg::ADDR_FLAGS: regRdData <= {5'h00, flags_ff};
                    rci_pkg::ADDR_LCNT:  regRdData <= lcnt_ff;
                    rci_pkg::ADDR_RXIN:  regRdData <= {7'h00, rxLevel};
                    default:             regRdData <= rci_pkg::DATA_ZERO;
                endcase
            end
        end
    end

endmodule

// *** logic/rci_pkg.sv ***
// Purpose: shared constants and types of the remote-control interrupt cause block
// Assumes: byte-wide registers on a plain strobe port, 16-bit address
// Notes:   offsets are byte addresses of the peripheral map
package rci_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_MASK  = 16'h5346;
    localparam logic [15:0] ADDR_FLAGS = 16'h5347;
    localparam logic [15:0] ADDR_LCNT  = 16'h5345;
    localparam logic [15:0] ADDR_RXIN  = 16'h5344;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int          BIT_UNDERFLOW = 0;
    localparam int          BIT_RISE      = 1;
    localparam int          BIT_FALL      = 2;
    localparam logic [2:0]  RST_MASK      = 3'h0;
    localparam logic [2:0]  RST_FLAGS     = 3'h0;
    localparam logic [7:0]  RST_LCNT      = 8'h00;
    localparam logic [7:0]  DATA_ZERO     = 8'h00;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [15:0] addr;
        logic [7:0]  wrData;
    } rci_bus_s;

    typedef struct packed {
        logic fall;
        logic rise;
        logic underflow;
    } rci_cause_s;

    typedef enum logic [1:0] {
        CNT_IDLE = 2'b01,
        CNT_RUN  = 2'b10
    } rci_cnt_e;

endpackage

// *** tb/rci_intc_model.sv ***
// Purpose: model of the chip interrupt controller
// Assumes: one level request line from the block
// Notes:   pending stays set until reset, no acknowledge path
module rci_intc_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // request and enable
    input wire logic irqReq,
    input wire logic srcEn,
    // toward the processor
    output logic     pending_ff,
    output logic     cpuIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_sys) begin
        if (srst)
            pending_ff <= 1'b0;
        else if (irqReq)
            pending_ff <= 1'b1;
    end
    assign cpuIrq = pending_ff & srcEn;
endmodule

// *** tb/rci_irq_flags_properties.sv ***
// Purpose: port checker of the interrupt cause block
// Assumes: clkEn is lowered only around a mask write, never around a read or a flag write
// Notes:   edge timing allows for the three-stage input filter
module rci_irq_flags_chk (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        clkEn,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [7:0]  regRdData,
    // events and request
    input wire logic        cntTick,
    input wire logic        rxPin,
    input wire logic        irqReq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_rd_idle_zero: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_reads_zero: assert property ($past(regRdEn && regAddr[15:2] != 14'h14d1) |-> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_flag_rsvd_zero: assert property ($past(regRdEn && regAddr == 16'h5347) |-> regRdData[7:3] == 5'h00)
        else $error("reserved flag bits not zero");
    a_mask_rsvd_zero: assert property ($past(regRdEn && regAddr == 16'h5346) |-> regRdData[7:3] == 5'h00)
        else $error("reserved mask bits not zero");
    a_irq_tracks_flags: assert property ($past(regRdEn && regAddr == 16'h5347) |-> (regRdData[2:0] != 3'h0) == $past(irqReq))
        else $error("request disagrees with flags");
    a_w1c_clears_all: assert property (($stable(rxPin) && !cntTick)[*5] ##0
        (regWrEn && regAddr == 16'h5347 && regWrData[2:0] == 3'h7) |=> !irqReq)
        else $error("write of ones did not clear");
    a_irq_has_cause: assert property ($rose(irqReq) |-> $past(cntTick) || $past(cntTick, 2)
        || $past(rxPin, 3) != $past(rxPin, 6))
        else $error("request without a cause");
    a_flags_sticky: assert property (irqReq && !(regWrEn && regAddr == 16'h5347) |=> irqReq)
        else $error("request dropped without a clear");
endmodule
bind rci_irq_flags rci_irq_flags_chk u_chk (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .cntTick(cntTick),
    .rxPin(rxPin), .irqReq(irqReq));

// *** tb/tb_remote_ctrl_irq_flags.sv ***
// Purpose: register-level tests of the interrupt cause block
// Assumes: rxPin changes are held at least seven cycles
// Notes:   ticks stand in for the running prescaler
module tb_remote_ctrl_irq_flags;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] MSK = rci_pkg::ADDR_MASK;
    localparam logic [15:0] FLG = rci_pkg::ADDR_FLAGS;
    localparam logic [15:0] CNT = rci_pkg::ADDR_LCNT;
    logic        clk_sys   = 1'b0;
    logic        srst      = 1'b1;
    logic        clkEn     = 1'b1;
    logic        regWrEn   = 1'b0;
    logic        regRdEn   = 1'b0;
    logic        cntTick   = 1'b0;
    logic        rxPin     = 1'b0;
    logic [15:0] regAddr   = 16'h0000;
    logic [7:0]  regWrData = 8'h00;
    logic [7:0]  regRdData;
    logic        irqReq;
    logic        cpuIrq;
    int          err_count = 0;
    int          checked   = 0;
    always #50 clk_sys = ~clk_sys;
    rci_irq_flags dut (.clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .cntTick(cntTick), .rxPin(rxPin),
        .irqReq(irqReq));
    rci_intc_model ic (.clk_sys(clk_sys), .srst(srst), .irqReq(irqReq), .srcEn(1'b1), .pending_ff(),
        .cpuIrq(cpuIrq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge clk_sys);
        regWrEn   <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask
    task automatic rx(input logic v);
        @(posedge clk_sys);
        rxPin <= v;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            cntTick <= 1'b1;
            @(posedge clk_sys);
            cntTick <= 1'b0;
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rd(MSK, 8'h00);
        rd(FLG, 8'h00);
        wr(MSK, 8'hff);
        rd(MSK, 8'h07);
        rd(16'h5348, 8'h00);
        $display("test registers done");
        wr(MSK, 8'h00);
        rx(1'b1);
        rd(FLG, 8'h00);
        wr(FLG, 8'h07);
        wr(MSK, 8'h06);
        rx(1'b0);
        rx(1'b1);
        rd(FLG, 8'h06);
        chk({7'h00, irqReq}, 8'h01);
        chk({7'h00, cpuIrq}, 8'h01);
        rd(rci_pkg::ADDR_RXIN, 8'h01);
        wr(FLG, 8'h00);
        wr(FLG, 8'h02);
        rd(FLG, 8'h04);
        wr(FLG, 8'h07);
        rd(FLG, 8'h00);
        chk({7'h00, irqReq}, 8'h00);
        $display("test edges done");
        wr(CNT, 8'h02);
        tick(2);
        rd(FLG, 8'h00);
        wr(MSK, 8'h01);
        wr(CNT, 8'h03);
        tick(2);
        rd(CNT, 8'h01);
        rd(FLG, 8'h00);
        tick(1);
        rd(FLG, 8'h01);
        rd(CNT, 8'h00);
        wr(FLG, 8'h07);
        rd(FLG, 8'h00);
        $display("test counter done");
        @(posedge clk_sys);
        clkEn <= 1'b0;
        wr(MSK, 8'h07);
        clkEn <= 1'b1;
        rd(MSK, 8'h01);
        $display("test clock enable done");
        wrap_up;
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up;
    end
endmodule
